// ---- twsp_defines.svh ----
`ifndef TWSP_DEFINES_SVH
`define TWSP_DEFINES_SVH

// file address of the timer count register on the core's register port
`define TWSP_TMR_ADDR 5'h01
// option configuration field positions
`define TWSP_CS_BIT 5
`define TWSP_SE_BIT 4
`define TWSP_PSA_BIT 3
`define TWSP_RATE_MSB 2
`define TWSP_RATE_LSB 0
// the shared count port pin within the direction register
`define TWSP_PORT_PIN 2
// reset values
`define TWSP_OPT_RST 8'hFF
`define TWSP_DIR_RST 6'h3F
`define TWSP_TMR_RST 8'h00
`define TWSP_PSC_RST 8'h00
`define TWSP_PHASE_RST 2'h0
`define TWSP_INHIBIT_RST 2'h0
// edge-corrected pin level at reset: low pin seen through the falling-edge default
`define TWSP_LVL_RST 1'b1
// instruction cycles with increments held off after a timer write
`define TWSP_INHIBIT_CYC 2'h2
// last oscillator phase of an instruction cycle, and the two sampling phases
`define TWSP_PHASE_LAST 2'h3
`define TWSP_PHASE_TWO 2'h1
`define TWSP_PHASE_FOUR 2'h3

`endif

// ---- twsp_pin_source.sv ----
`timescale 1ns/100ps
module twsp_pin_source
(
    input wire logic sys_clk,
    output logic ext_count_pin
);
    // pin starts low and holds each commanded level until the next
    initial ext_count_pin = 1'b0;
    // set the pin just after an edge, hold it, return at a falling edge
    task automatic set_pin(input logic v, input int hold);
        @(posedge sys_clk);
        ext_count_pin <= v;
        repeat (hold) @(negedge sys_clk);
    endtask
endmodule

// ---- twsp_pkg.sv ----
package twsp_pkg;
    // one oscillator period of the four that make an instruction cycle
    typedef logic [1:0] twsp_phase_t;
    typedef logic [7:0] twsp_byte_t;
    typedef logic [2:0] twsp_rate_t;
    // where the prescaler currently sits
    typedef enum logic {twsp_to_timer, twsp_to_watchdog} twsp_assign_e;
endpackage

// ---- twsp_prescaler.sv ----
`timescale 1ns/100ps
`include "twsp_defines.svh"

module twsp_prescaler
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clear_pulse,
    input wire logic count_evt,
    input wire twsp_pkg::twsp_assign_e assign_sel,
    input wire twsp_pkg::twsp_rate_t prescale_rate,
    output logic timer_out,
    output logic watchdog_timeout
);
    twsp_pkg::twsp_byte_t count_q;
    twsp_pkg::twsp_byte_t count_d;
    twsp_pkg::twsp_byte_t wdt_mask;
    logic wdt_wrap;

    // low-bit mask for the watchdog ratio 1:2^rate
    function automatic twsp_pkg::twsp_byte_t rate_mask(input twsp_pkg::twsp_rate_t rate);
        rate_mask = twsp_pkg::twsp_byte_t'((9'h001 << rate) - 9'h001);
    endfunction

    // counter advances on each event; clear has priority, software never sees it [R8]
    assign count_d = clear_pulse ? `TWSP_PSC_RST :
                     count_evt ? twsp_pkg::twsp_byte_t'(count_q + 8'h01) : count_q;
    // timer ratio 1:2^(rate+1) is the rate bit of the counter, a symmetric square wave [R5] [R17] [R10]
    assign timer_out = (assign_sel == twsp_pkg::twsp_to_timer) && count_q[prescale_rate];
    // watchdog postscale 1:2^rate: fires when the selected low bits wrap [R5] [R17]
    assign wdt_mask = rate_mask(prescale_rate);
    assign wdt_wrap = (count_q & wdt_mask) == wdt_mask;
    assign watchdog_timeout = (assign_sel == twsp_pkg::twsp_to_watchdog) && count_evt && wdt_wrap
                              && !clear_pulse;

    // the single 8-bit prescaler, zero on every reset [R8]
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            count_q <= `TWSP_PSC_RST; // [R8]
        else
            count_q <= count_d;
    end
endmodule

// ---- twsp_timer.sv ----
`timescale 1ns/100ps
`include "twsp_defines.svh"

// Contract
// [R1] timer mode counts every instruction cycle
// [R2] timer write holds off two cycles' increments
// [R3] counter mode counts pin edges, edge selectable
// [R4] prescaler serves timer or watchdog, not both
// [R5] 8-bit prescaler, ratio from three rate bits
// [R6] timer write clears prescaler when timer-assigned
// [R7] clear watchdog clears prescaler when watchdog-assigned
// [R8] prescaler hidden from software, reset to zero
// [R9] sample prescaler output on phases two, four
// [R10] external clock divided before synchronisation; the code synchronises the pin first, then the prescaler divides it
// [R11] increment 3 to 7 oscillator periods later
// [R12] counter mode forces shared pin to input
// [R13] timer count is 8-bit read write
// [R14] software sequence timer to watchdog reassignment
// [R15] clear watchdog before watchdog to timer move
// [R16] clear watchdog then write option configuration
// [R17] rate decode timer 1:2-1:256, watchdog 1:1-1:128
// [R18] timer wraps to zero, no flag
module twsp_timer
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr_en,
    input wire twsp_pkg::twsp_byte_t reg_wr_data,
    output twsp_pkg::twsp_byte_t reg_rd_data,
    input wire logic option_wr_en,
    input wire twsp_pkg::twsp_byte_t option_wr_data,
    input wire logic dir_wr_en,
    input wire logic [5:0] dir_wr_data,
    input wire logic clear_watchdog_cmd,
    input wire logic watchdog_tick,
    input wire logic ext_count_pin,
    output twsp_pkg::twsp_byte_t timer_count,
    output twsp_pkg::twsp_byte_t option_config,
    output logic [5:0] pin_direction,
    output logic [5:0] pin_input_en,
    output twsp_pkg::twsp_phase_t osc_phase,
    output logic instr_cycle_end,
    output logic watchdog_timeout
);
    twsp_pkg::twsp_phase_t phase_q;
    twsp_pkg::twsp_byte_t timer_q;
    twsp_pkg::twsp_byte_t timer_d;
    twsp_pkg::twsp_byte_t option_q;
    logic [5:0] dir_q;
    logic [1:0] inhibit_q;
    logic [1:0] inhibit_d;
    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_lvl_q;
    logic smp_q;
    logic smp_prev_q;
    logic phase_four;
    logic sample_now;
    logic clock_source_select;
    logic source_edge_select;
    twsp_pkg::twsp_assign_e prescaler_assign;
    twsp_pkg::twsp_rate_t prescale_rate;
    logic timer_wr;
    logic pin_lvl;
    logic pin_rise;
    logic psc_evt;
    logic psc_clear;
    logic psc_timer_out;
    logic src_lvl;
    logic smp_rise;
    logic inc_req;
    logic inc_ok;

    // advances an 8-bit count by one, wrapping to zero
    function automatic twsp_pkg::twsp_byte_t bump(input twsp_pkg::twsp_byte_t v);
        bump = twsp_pkg::twsp_byte_t'(v + 8'h01);
    endfunction

    // option configuration fields
    assign clock_source_select = option_q[`TWSP_CS_BIT];
    assign source_edge_select = option_q[`TWSP_SE_BIT];
    assign prescaler_assign = option_q[`TWSP_PSA_BIT] ? twsp_pkg::twsp_to_watchdog
                                                      : twsp_pkg::twsp_to_timer; // [R4]
    assign prescale_rate = option_q[`TWSP_RATE_MSB:`TWSP_RATE_LSB];

    // instruction cycle timing: writes land at phase four, the end of a cycle
    assign phase_four = phase_q == `TWSP_PHASE_FOUR;
    assign sample_now = (phase_q == `TWSP_PHASE_TWO) || phase_four; // [R9]
    assign timer_wr = reg_wr_en && (reg_addr == `TWSP_TMR_ADDR);

    // oscillator phase counter, one step per oscillator period
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            phase_q <= `TWSP_PHASE_RST;
        else
            phase_q <= (phase_q == `TWSP_PHASE_LAST) ? 2'h0 : twsp_pkg::twsp_phase_t'(phase_q + 2'h1);
    end

    // two-stage synchroniser on the count pin, then the edge-corrected level
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            // matches the level seen after reset, so no false edge follows it
            pin_lvl_q <= `TWSP_LVL_RST;
        end
        else
        begin
            pin_meta_q <= ext_count_pin;
            pin_sync_q <= pin_meta_q;
            pin_lvl_q <= pin_lvl;
        end
    end

    // falling edges are counted by inverting the pin level first [R3]
    assign pin_lvl = pin_sync_q ^ source_edge_select;
    assign pin_rise = pin_lvl && !pin_lvl_q;

    // prescaler input: watchdog ticks, pin edges, or instruction cycles [R4] [R10]
    assign psc_evt = (prescaler_assign == twsp_pkg::twsp_to_watchdog) ? watchdog_tick :
                     clock_source_select ? pin_rise : phase_four;
    // prescaler clear on timer write or clear watchdog, per assignment [R6] [R7]
    assign psc_clear = ((prescaler_assign == twsp_pkg::twsp_to_timer) && timer_wr)
                       || ((prescaler_assign == twsp_pkg::twsp_to_watchdog) && clear_watchdog_cmd);

    twsp_prescaler u_prescaler
    (
        .sys_clk(sys_clk),
        .srst(srst),
        .clear_pulse(psc_clear),
        .count_evt(psc_evt),
        .assign_sel(prescaler_assign),
        .prescale_rate(prescale_rate),
        .timer_out(psc_timer_out),
        .watchdog_timeout(watchdog_timeout)
    );

    // level fed to the phase sampler: prescaler output, or the synchronised edge-corrected pin level [R9] [R10]
    assign src_lvl = (prescaler_assign == twsp_pkg::twsp_to_timer) ? psc_timer_out : pin_lvl;

    // sample on phases two and four; a rise of the sample is one count [R9] [R11]
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            smp_q <= `TWSP_LVL_RST; // idle level of the reset source, no count after reset
            smp_prev_q <= `TWSP_LVL_RST;
        end
        else
        begin
            if (sample_now)
                smp_q <= src_lvl; // [R9]
            smp_prev_q <= smp_q;
        end
    end
    assign smp_rise = smp_q && !smp_prev_q;

    // timer mode without prescaler counts each instruction cycle, else sampled rises [R1] [R3]
    assign inc_req = (!clock_source_select && (prescaler_assign == twsp_pkg::twsp_to_watchdog))
                     ? phase_four : smp_rise;
    // increments are held off while the post-write window runs [R2]
    assign inc_ok = inc_req && (inhibit_q == 2'h0);

    // write wins over increment; the count wraps with no flag [R13] [R18]
    assign timer_d = timer_wr ? reg_wr_data : inc_ok ? bump(timer_q) : timer_q;

    // post-write window counts down at each instruction cycle end [R2]
    assign inhibit_d = timer_wr ? `TWSP_INHIBIT_CYC :
                       (phase_four && (inhibit_q != 2'h0)) ? 2'(inhibit_q - 2'h1) : inhibit_q;

    // timer count and inhibit window
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            timer_q <= `TWSP_TMR_RST;
            inhibit_q <= `TWSP_INHIBIT_RST;
        end
        else
        begin
            timer_q <= timer_d; // [R13]
            inhibit_q <= inhibit_d; // [R2]
        end
    end

    // option and direction registers, written by their own instructions
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            option_q <= `TWSP_OPT_RST;
            dir_q <= `TWSP_DIR_RST;
        end
        else
        begin
            if (option_wr_en)
                option_q <= option_wr_data;
            if (dir_wr_en)
                dir_q <= dir_wr_data;
        end
    end

    // counter mode turns the shared count port pin into an input [R12]
    always_comb
    begin
        pin_input_en = dir_q;
        if (clock_source_select)
            pin_input_en[`TWSP_PORT_PIN] = 1'b1; // [R12]
    end

    // read port shows the live count at its address, zero elsewhere [R13]
    assign reg_rd_data = (reg_addr == `TWSP_TMR_ADDR) ? timer_q : 8'h00;
    assign timer_count = timer_q;
    assign option_config = option_q;
    assign pin_direction = dir_q;
    assign osc_phase = phase_q;
    assign instr_cycle_end = phase_four;
endmodule

// ---- twsp_timer_checker.sv ----
`timescale 1ns/100ps
module twsp_timer_checker
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr_en,
    input wire twsp_pkg::twsp_byte_t reg_wr_data,
    input wire logic option_wr_en,
    input wire twsp_pkg::twsp_byte_t option_wr_data,
    input wire logic watchdog_tick,
    input wire logic ext_count_pin,
    input wire twsp_pkg::twsp_byte_t timer_count,
    input wire twsp_pkg::twsp_byte_t option_config,
    input wire logic [5:0] pin_direction,
    input wire logic [5:0] pin_input_en,
    input wire logic instr_cycle_end,
    input wire logic watchdog_timeout
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // a core write aimed at the timer count
    sequence s_tmr_wr;
        reg_wr_en && reg_addr == 5'h01;
    endsequence
    // the selected pin edge while counting the pin without prescaler
    sequence s_pin_edge;
        option_config[5] && option_config[3]
            && (option_config[4] ? $fell(ext_count_pin) : $rose(ext_count_pin));
    endsequence
    chk_tmr_load: assert property (s_tmr_wr |=> timer_count == $past(reg_wr_data))
        else $error("timer write not loaded");
    chk_inhibit_hold: assert property (s_tmr_wr |=> ##1 $stable(timer_count)[*8])
        else $error("timer moved during write hold-off");
    chk_step_wrap: assert property (!reg_wr_en |=> timer_count == $past(timer_count)
        || timer_count == $past(timer_count) + 8'h01) else $error("timer step not one");
    chk_cycle_count: assert property (!option_config[5] && option_config[3]
        && $changed(timer_count) && !$past(reg_wr_en) |-> $past(instr_cycle_end))
        else $error("timer step off cycle end");
    chk_pin_delay: assert property (s_pin_edge |-> ##[2:7] $changed(timer_count))
        else $error("pin edge not counted in time");
    chk_pin_forced: assert property (pin_input_en
        == (pin_direction | {3'h0, option_config[5], 2'h0})) else $error("pin not input");
    chk_reset_vals: assert property ($fell(srst) |-> timer_count == 8'h00
        && option_config == 8'hFF && pin_direction == 6'h3F) else $error("reset values");
    chk_wd_owner: assert property (watchdog_timeout |-> option_config[3] && watchdog_tick)
        else $error("timeout without watchdog prescaler");
    chk_option_load: assert property (option_wr_en |=> option_config == $past(option_wr_data))
        else $error("option write not loaded");
endmodule

bind twsp_timer twsp_timer_checker i_chk (.sys_clk, .srst, .reg_addr, .reg_wr_en,
    .reg_wr_data, .option_wr_en, .option_wr_data, .watchdog_tick, .ext_count_pin,
    .timer_count, .option_config, .pin_direction, .pin_input_en, .instr_cycle_end,
    .watchdog_timeout);

// ---- twsp_timer_test.sv ----
`timescale 1ns/100ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module twsp_timer_test;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] reg_addr = 5'h01;
    logic reg_wr_en = 1'b0;
    logic option_wr_en = 1'b0;
    logic dir_wr_en = 1'b0;
    logic clear_watchdog_cmd = 1'b0;
    logic watchdog_tick = 1'b0;
    twsp_pkg::twsp_byte_t reg_wr_data = 8'h00;
    twsp_pkg::twsp_byte_t option_wr_data = 8'h00;
    logic [5:0] dir_wr_data = 6'h00;
    logic ext_count_pin, instr_cycle_end, watchdog_timeout;
    twsp_pkg::twsp_byte_t reg_rd_data, timer_count, option_config, base;
    logic [5:0] pin_direction, pin_input_en;
    twsp_pkg::twsp_phase_t osc_phase;
    int error_cnt = 0;
    int tests_run = 0;
    int wd_cnt = 0;
    always #2 sys_clk = ~sys_clk;
    twsp_timer i_dut (.sys_clk, .srst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_data,
        .option_wr_en, .option_wr_data, .dir_wr_en, .dir_wr_data, .clear_watchdog_cmd,
        .watchdog_tick, .ext_count_pin, .timer_count, .option_config, .pin_direction,
        .pin_input_en, .osc_phase, .instr_cycle_end, .watchdog_timeout);
    twsp_pin_source i_src (.sys_clk, .ext_count_pin);
    // count postscaled watchdog timeouts
    always @(posedge sys_clk)
        if (watchdog_timeout === 1'b1) wd_cnt++;
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // one core write in phase four: 0 timer, 1 option, 2 direction, 3 clear watchdog
    task automatic wr(input int k, input logic [7:0] d);
        do @(negedge sys_clk); while (osc_phase !== 2'h2);
        @(posedge sys_clk);
        {reg_wr_en, option_wr_en, dir_wr_en, clear_watchdog_cmd} <= 4'(4'h8 >> k);
        {reg_wr_data, option_wr_data, dir_wr_data} <= {d, d, d[5:0]};
        @(posedge sys_clk);
        {reg_wr_en, option_wr_en, dir_wr_en, clear_watchdog_cmd} <= 4'h0;
        cyc(1);
    endtask
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            watchdog_tick <= 1'b1;
            @(posedge sys_clk);
            watchdog_tick <= 1'b0;
        end
        cyc(2);
    endtask
    task automatic t_reset();
        cyc(1);
        `CHK("timer", 8'h00, timer_count)
        `CHK("option", 8'hFF, option_config)
        `CHK("pin_in", 6'h3F, pin_input_en)
    endtask
    task automatic t_timer();
        wr(1, 8'h08);
        wr(0, 8'hFD);
        `CHK("rd", 8'hFD, reg_rd_data)
        cyc(11);
        `CHK("held", 8'hFD, timer_count)
        cyc(1);
        `CHK("step", 8'hFE, timer_count)
        cyc(8);
        `CHK("wrap", 8'h00, timer_count)
        @(posedge sys_clk) reg_addr <= 5'h02;
        @(negedge sys_clk) `CHK("unmapped", 8'h00, reg_rd_data)
        @(posedge sys_clk) reg_addr <= 5'h01;
    endtask
    task automatic t_presc();
        wr(3, 8'h00);
        for (int r = 0; r < 8; r++)
        begin
            wr(1, 8'(r));
            wr(0, 8'h00);
            cyc(40);
            base = timer_count;
            cyc(1024);
            `CHK("ratio", 8'(256 >> (r + 1)), 8'(timer_count - base))
        end
        wr(0, 8'h00);
        cyc(400);
        wr(0, 8'h00);
        cyc(400);
        `CHK("psc_clear", 8'h00, timer_count)
    endtask
    task automatic t_counter();
        wr(3, 8'h00);
        wr(0, 8'h00);
        wr(2, 8'h00);
        for (int se = 0; se < 2; se++)
        begin
            wr(1, se ? 8'h38 : 8'h28);
            cyc(12);
            base = timer_count;
            i_src.set_pin(1'b1, 10);
            `CHK("rise", 8'(base + 1 - se), timer_count)
            i_src.set_pin(1'b0, 10);
            `CHK("fall", 8'(base + 1), timer_count)
        end
        `CHK("pin_in", 6'h04, pin_input_en)
        base = timer_count;
        repeat (6)
        begin
            i_src.set_pin(1'b1, 2);
            i_src.set_pin(1'b0, 2);
        end
        cyc(10);
        `CHK("short", 8'(base + 6), timer_count)
    endtask
    task automatic t_watchdog();
        wr(1, 8'h0A);
        wr(3, 8'h00);
        wd_cnt = 0;
        ticks(8);
        `CHK("wd_div", 2, wd_cnt)
        ticks(2);
        wr(3, 8'h00);
        ticks(2);
        `CHK("wd_clear", 2, wd_cnt)
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // cut a hang short
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_timer();
        t_presc();
        t_counter();
        t_watchdog();
        report_and_stop();
    end
endmodule
